/* File: shared/rla_pkg.sv */
/*
 * Constants for the receive lane alignment and status block: register
 * offsets, reset values, field positions, event bit positions and the
 * CRC24 polynomial.
 * Assumes a 32-bit register port with byte addresses.
 */
package rla_pkg;

  // ---------------------------------------------------------------
  // Register offsets.
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_MF_LEN    = 8'h04;
  localparam logic [7:0] OFS_BURST     = 8'h08;
  localparam logic [7:0] OFS_LANE_MASK = 8'h0c;
  localparam logic [7:0] OFS_STATUS    = 8'h10;
  localparam logic [7:0] OFS_INT_STAT  = 8'h14;
  localparam logic [7:0] OFS_INT_MASK  = 8'h18;
  localparam logic [7:0] OFS_LANE_LEN  = 8'h1c;
  localparam logic [7:0] OFS_LANE_REP  = 8'h20;

  // ---------------------------------------------------------------
  // Field positions and reset values.
  // ---------------------------------------------------------------
  localparam int CTRL_SOFT_RESET_BIT = 0;
  localparam int CTRL_LOOPBACK_BIT   = 1;
  localparam int BURST_MAX_LSB       = 0;
  localparam int BURST_MIN_LSB       = 8;
  localparam logic [15:0] MF_LEN_RST    = 16'h0800;
  localparam logic [1:0]  BURST_MAX_RST = 2'h3;
  localparam logic [7:0]  BURST_MIN_RST = 8'h20;
  localparam logic [11:0] LANE_MASK_RST = 12'hfff;
  localparam logic [2:0]  REPEAT_LIMIT  = 3'h4;

  // Low-bit mask: burst lengths other than at packet end are whole multiples of 8 bytes.
  localparam logic [2:0]  BURST_GRAIN_MASK = 3'h7;
  // Byte step of the maximum-burst encoding: 0x0 = 64 ... 0x3 = 256.
  localparam logic [11:0] BURST_MAX_STEP   = 12'h040;

  // ---------------------------------------------------------------
  // Event bits of the interrupt status and mask registers.
  // ---------------------------------------------------------------
  localparam int EV_MISALIGN  = 0;
  localparam int EV_ALIGN_ERR = 1;
  localparam int EV_CRC       = 2;
  localparam int EV_MSOP      = 3;
  localparam int EV_MEOP      = 4;
  localparam int EV_OVERFLOW  = 5;
  localparam int EV_BURST     = 6;
  localparam int EV_BURSTMAX  = 7;
  localparam int EV_LANE_LEN  = 8;
  localparam int EV_LANE_REP  = 9;
  localparam int EV_W         = 10;

  // ---------------------------------------------------------------
  // CRC24 over control words.
  // ---------------------------------------------------------------
  localparam logic [23:0] CRC24_POLY = 24'h328b63;
  localparam logic [23:0] CRC24_INIT = 24'hffffff;

  // ---------------------------------------------------------------
  // Alignment states, Gray coded along hunt, wait, locked.
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ALN_HUNT   = 2'b00,
    ALN_SEEN   = 2'b01,
    ALN_LOCKED = 2'b11
  } rla_aln_t;

endpackage

/* File: rtl/rla_crc24_step.sv */
/*
 * One combinational CRC24 step over a data word, most significant bit
 * first.
 * Assumes the caller holds the running remainder in a register.
 */
`timescale 1ns/1ns
module rla_crc24_step
  import rla_pkg::*;
#(
  parameter int DW = 64
) (
  input  wire logic [23:0]   crc_in,
  input  wire logic [DW-1:0] data,
  output logic      [23:0]   crc_out
);

  // ---------------------------------------------------------------
  // Bitwise polynomial division.
  // ---------------------------------------------------------------
  always_comb begin
    logic [23:0] c;
    c = crc_in;
    for (int i = DW - 1; i >= 0; i--) begin
      if (c[23] ^ data[i]) begin
        c = {c[22:0], 1'b0} ^ CRC24_POLY;
      end else begin
        c = {c[22:0], 1'b0};
      end
    end
    crc_out = c;
  end

endmodule

/* File: rtl/rla_rx_status.sv */
/*
 * Receive lane alignment, stream correction and status reporting for a
 * twelve-lane packet link receiver, with its register file.
 * Assumes lane logic delivers de-skewed per-lane word strobes and meta
 * frame sync marks on clk, and that all inputs are synchronous to clk.
 */
// Design decisions made here: the register offsets and strobed register access.
// Functional notes
// - Per lane, flag meta frames whose length differs from configured length.
// - Per lane, flag meta frame errors repeating in succession.
// - Aligned is high only while all active lanes are aligned and de-skewed.
// - Flag misalignment when sync word is not on all active lanes together.
// - Misalignment stays low until sync seen on every active lane once.
// - Flag alignment loss on error while aligning or loss of alignment.
// - Check CRC24 over each control word span against received value.
// - Insert missing start-of-packet and flag it.
// - Supply missing end-of-packet and flag it.
// - Flag overflow when user side drains too slowly; normally zero.
// - Maximum burst code 0..3 means 64, 128, 192, 256 bytes.
// - Flag bursts shorter than minimum or otherwise of illegal length.
// - Present transmit user data as a 768-bit bus to the transceiver.
// - Software drives a single transceiver reset output.
// - Software drives a single transceiver loopback output.
// - All status outputs are generated on the user bus clock.
`timescale 1ns/1ns
module rla_rx_status
  import rla_pkg::*;
#(
  parameter int LANES = 12,
  parameter int DW    = 768,
  parameter int CW    = 64
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  // Register port.
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_we,
  input  wire logic             reg_re,
  output logic      [31:0]      reg_rdata,
  output logic                  irq,
  // Lane logic.
  input  wire logic [LANES-1:0] lane_word_valid,
  input  wire logic [LANES-1:0] lane_mf_sync,
  input  wire logic [LANES-1:0] lane_mf_bad,
  // Control word spans.
  input  wire logic             ctl_word_valid,
  input  wire logic             ctl_word_first,
  input  wire logic             ctl_word_last,
  input  wire logic [CW-1:0]    ctl_word_data,
  input  wire logic [23:0]      ctl_crc_rx,
  // Received packet beats.
  input  wire logic             rx_beat_valid,
  input  wire logic             rx_beat_sop,
  input  wire logic             rx_beat_eop,
  input  wire logic             rx_burst_end,
  input  wire logic [6:0]       rx_beat_bytes,
  input  wire logic [DW-1:0]    serdes_rx_data,
  // User side of the received stream.
  output logic                  user_valid,
  output logic                  user_sop,
  output logic                  user_eop,
  output logic      [DW-1:0]    user_data,
  input  wire logic             user_ready,
  // Transmit path toward the transceiver.
  input  wire logic [DW-1:0]    user_tx_data,
  output logic      [DW-1:0]    serdes_tx_data,
  output logic                  transceiver_soft_reset,
  output logic                  transceiver_loopback_ctl,
  // Status.
  output logic      [LANES-1:0] lane_frame_length_fault,
  output logic      [LANES-1:0] lane_frame_repeat_fault,
  output logic                  rx_aligned,
  output logic                  rx_misaligned,
  output logic                  rx_align_fault,
  output logic                  control_crc_fault,
  output logic                  rx_missing_sop,
  output logic                  rx_missing_eop,
  output logic                  rx_overflow,
  output logic                  rx_burst_fault,
  output logic                  rx_burstmax_fault
);

  // ---------------------------------------------------------------
  // Helpers.
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  function automatic logic [11:0] burst_max_bytes(input logic [1:0] code);
    return BURST_MAX_STEP * ({10'h000, code} + 12'h001);
  endfunction

  // ---------------------------------------------------------------
  // Register file.
  // ---------------------------------------------------------------
  logic [1:0]       ctrl_r;
  logic [15:0]      mf_len_r;
  logic [1:0]       burst_max_r;
  logic [7:0]       burst_min_r;
  logic [LANES-1:0] lane_mask_r;
  logic [EV_W-1:0]  int_stat_r;
  logic [EV_W-1:0]  int_mask_r;
  logic [EV_W-1:0]  events;
  logic [EV_W-1:0]  w1c;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_r      <= 2'h0;
      mf_len_r    <= MF_LEN_RST;
      burst_max_r <= BURST_MAX_RST;
      burst_min_r <= BURST_MIN_RST;
      lane_mask_r <= LANE_MASK_RST;
      int_mask_r  <= '0;
    end else if (reg_we) begin
      if (hit(reg_addr, OFS_CTRL)) begin
        ctrl_r <= reg_wdata[1:0];
      end
      if (hit(reg_addr, OFS_MF_LEN)) begin
        mf_len_r <= reg_wdata[15:0];
      end
      if (hit(reg_addr, OFS_BURST)) begin
        burst_max_r <= reg_wdata[BURST_MAX_LSB +: 2];
        burst_min_r <= reg_wdata[BURST_MIN_LSB +: 8];
      end
      if (hit(reg_addr, OFS_LANE_MASK)) begin
        lane_mask_r <= reg_wdata[LANES-1:0];
      end
      if (hit(reg_addr, OFS_INT_MASK)) begin
        int_mask_r <= reg_wdata[EV_W-1:0];
      end
    end
  end

  assign transceiver_soft_reset   = ctrl_r[CTRL_SOFT_RESET_BIT];
  assign transceiver_loopback_ctl = ctrl_r[CTRL_LOOPBACK_BIT];

  // A new event in the cycle of its clear keeps the bit set.
  assign w1c = (reg_we && hit(reg_addr, OFS_INT_STAT)) ?
               reg_wdata[EV_W-1:0] : '0;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      int_stat_r <= '0;
    end else begin
      int_stat_r <= (int_stat_r & ~w1c) | events;
    end
  end

  assign irq = |(int_stat_r & int_mask_r);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rdata <= 32'h0;
    end else if (reg_re) begin
      case (reg_addr)
        OFS_CTRL:      reg_rdata <= {30'h0, ctrl_r};
        OFS_MF_LEN:    reg_rdata <= {16'h0, mf_len_r};
        OFS_BURST:     reg_rdata <= {16'h0, burst_min_r, 6'h0, burst_max_r};
        OFS_LANE_MASK: reg_rdata <= {20'h0, lane_mask_r};
        OFS_STATUS:    reg_rdata <= {30'h0, rx_misaligned, rx_aligned};
        OFS_INT_STAT:  reg_rdata <= {22'h0, int_stat_r};
        OFS_INT_MASK:  reg_rdata <= {22'h0, int_mask_r};
        OFS_LANE_LEN:  reg_rdata <= {20'h0, lane_frame_length_fault};
        OFS_LANE_REP:  reg_rdata <= {20'h0, lane_frame_repeat_fault};
        default:       reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // Per-lane meta frame checks.
  // ---------------------------------------------------------------
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [15:0] words_r;
    logic        started_r;
    logic [2:0]  rep_r;
    logic        len_bad;
    logic        frame_bad;

    assign len_bad   = started_r && (words_r != mf_len_r);
    assign frame_bad = len_bad || lane_mf_bad[g];

    always_ff @(posedge clk) begin
      if (!nrst) begin
        words_r   <= 16'h0;
        started_r <= 1'b0;
      end else if (lane_mf_sync[g]) begin
        words_r   <= 16'h1;
        started_r <= 1'b1;
      end else if (lane_word_valid[g]) begin
        words_r <= words_r + 16'h1;
      end
    end

    always_ff @(posedge clk) begin
      if (!nrst) begin
        lane_frame_length_fault[g] <= 1'b0;
      end else if (lane_mf_sync[g]) begin
        lane_frame_length_fault[g] <= len_bad;
      end
    end

    always_ff @(posedge clk) begin
      if (!nrst) begin
        rep_r                      <= 3'h0;
        lane_frame_repeat_fault[g] <= 1'b0;
      end else if (lane_mf_sync[g]) begin
        if (!frame_bad) begin
          rep_r                      <= 3'h0;
          lane_frame_repeat_fault[g] <= 1'b0;
        end else begin
          if (rep_r != REPEAT_LIMIT) begin
            rep_r <= rep_r + 3'h1;
          end
          lane_frame_repeat_fault[g] <= (rep_r + 3'h1 >= REPEAT_LIMIT);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Lane alignment.
  // ---------------------------------------------------------------
  rla_aln_t         aln_r;
  logic [LANES-1:0] seen_r;
  logic             any_sync;
  logic             all_sync;
  logic             skew;

  assign any_sync = |(lane_mf_sync & lane_mask_r);
  assign all_sync = &(lane_mf_sync | ~lane_mask_r);
  assign skew     = any_sync && !all_sync;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      seen_r <= '0;
    end else begin
      seen_r <= seen_r | lane_mf_sync;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      aln_r <= ALN_HUNT;
    end else begin
      case (aln_r)
        ALN_HUNT: begin
          if (&(seen_r | lane_mf_sync | ~lane_mask_r)) begin
            aln_r <= ALN_SEEN;
          end
        end
        ALN_SEEN: begin
          if (any_sync && all_sync) begin
            aln_r <= ALN_LOCKED;
          end
        end
        ALN_LOCKED: begin
          if (skew) begin
            aln_r <= ALN_SEEN;
          end
        end
        default: aln_r <= ALN_HUNT;
      endcase
    end
  end

  assign rx_aligned = (aln_r == ALN_LOCKED);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_misaligned  <= 1'b0;
      rx_align_fault <= 1'b0;
    end else begin
      rx_misaligned  <= skew && (aln_r != ALN_HUNT);
      rx_align_fault <= skew && (aln_r != ALN_HUNT);
    end
  end

  // ---------------------------------------------------------------
  // Control word CRC24.
  // ---------------------------------------------------------------
  logic [23:0] crc_r;
  logic [23:0] crc_nxt;

  rla_crc24_step #(
    .DW (CW)
  ) u_crc (
    .crc_in  (ctl_word_first ? CRC24_INIT : crc_r),
    .data    (ctl_word_data),
    .crc_out (crc_nxt)
  );

  always_ff @(posedge clk) begin
    if (!nrst) begin
      crc_r             <= CRC24_INIT;
      control_crc_fault <= 1'b0;
    end else begin
      control_crc_fault <= ctl_word_valid && ctl_word_last &&
                           (crc_nxt != ctl_crc_rx);
      if (ctl_word_valid) begin
        crc_r <= ctl_word_last ? CRC24_INIT : crc_nxt;
      end
    end
  end

  // ---------------------------------------------------------------
  // Stream correction and hand-off to the user side.
  // ---------------------------------------------------------------
  logic          hold_valid_r;
  logic          hold_sop_r;
  logic          hold_eop_r;
  logic [DW-1:0] hold_data_r;
  logic          in_pkt_r;
  logic          fix_sop;
  logic          fix_eop;
  logic          out_free;
  logic          ovf;
  logic          take;

  assign out_free = !user_valid || user_ready;
  assign ovf      = rx_beat_valid && hold_valid_r && !out_free;
  assign take     = rx_beat_valid && !ovf;
  assign fix_sop  = take && !rx_beat_sop && !in_pkt_r;
  assign fix_eop  = take && rx_beat_sop && in_pkt_r;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      in_pkt_r     <= 1'b0;
      hold_valid_r <= 1'b0;
      hold_sop_r   <= 1'b0;
      hold_eop_r   <= 1'b0;
    end else if (take) begin
      in_pkt_r     <= !rx_beat_eop;
      hold_valid_r <= 1'b1;
      hold_sop_r   <= rx_beat_sop || fix_sop;
      hold_eop_r   <= rx_beat_eop;
    end
  end

  always_ff @(posedge clk) begin
    if (take) begin
      hold_data_r <= serdes_rx_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      user_valid <= 1'b0;
      user_sop   <= 1'b0;
      user_eop   <= 1'b0;
    end else if (take && hold_valid_r) begin
      user_valid <= 1'b1;
      user_sop   <= hold_sop_r;
      user_eop   <= hold_eop_r || fix_eop;
    end else if (user_ready) begin
      user_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      user_data <= '0;
    end else if (take && hold_valid_r) begin
      user_data <= hold_data_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_missing_sop <= 1'b0;
      rx_missing_eop <= 1'b0;
      rx_overflow    <= 1'b0;
    end else begin
      rx_missing_sop <= fix_sop;
      rx_missing_eop <= fix_eop;
      rx_overflow    <= ovf;
    end
  end

  // ---------------------------------------------------------------
  // Burst length checks.
  // ---------------------------------------------------------------
  logic [11:0] burst_len_r;
  logic [11:0] burst_len;
  logic        burst_done;
  logic        too_short;
  logic        bad_grain;
  logic        too_long;

  assign burst_len  = burst_len_r + {5'h00, rx_beat_bytes};
  assign burst_done = take && (rx_burst_end || rx_beat_eop);
  assign too_short  = !rx_beat_eop && (burst_len < {4'h0, burst_min_r});
  assign bad_grain  = !rx_beat_eop && ((burst_len[2:0] & BURST_GRAIN_MASK)
                      != 3'h0);
  assign too_long   = burst_len > burst_max_bytes(burst_max_r);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      burst_len_r <= 12'h0;
    end else if (burst_done) begin
      burst_len_r <= 12'h0;
    end else if (take) begin
      burst_len_r <= burst_len;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_burst_fault    <= 1'b0;
      rx_burstmax_fault <= 1'b0;
    end else begin
      rx_burst_fault    <= burst_done &&
                           (too_short || bad_grain || too_long);
      rx_burstmax_fault <= burst_done && too_long;
    end
  end

  // ---------------------------------------------------------------
  // Transmit data toward the transceiver.
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      serdes_tx_data <= '0;
    end else begin
      serdes_tx_data <= user_tx_data;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt events.
  // ---------------------------------------------------------------
  always_comb begin
    events               = '0;
    events[EV_MISALIGN]  = rx_misaligned;
    events[EV_ALIGN_ERR] = rx_align_fault;
    events[EV_CRC]       = control_crc_fault;
    events[EV_MSOP]      = rx_missing_sop;
    events[EV_MEOP]      = rx_missing_eop;
    events[EV_OVERFLOW]  = rx_overflow;
    events[EV_BURST]     = rx_burst_fault;
    events[EV_BURSTMAX]  = rx_burstmax_fault;
    events[EV_LANE_LEN]  = |lane_frame_length_fault;
    events[EV_LANE_REP]  = |lane_frame_repeat_fault;
  end

endmodule

/* File: tb/rla_rx_status_checker.sv */
/*
 * Port checker for rla_rx_status.
 * Assumes one clock and the default lane mask of all twelve lanes.
 */
`timescale 1ns/1ns
module rla_rx_status_checker (
  input wire logic         clk,
  input wire logic         nrst,
  input wire logic [767:0] user_tx_data,
  input wire logic [767:0] serdes_tx_data,
  input wire logic [11:0]  lane_mf_sync,
  input wire logic         rx_aligned,
  input wire logic         rx_misaligned,
  input wire logic         rx_beat_valid,
  input wire logic         rx_beat_sop,
  input wire logic         rx_beat_eop,
  input wire logic         rx_burst_end,
  input wire logic         user_valid,
  input wire logic         user_ready,
  input wire logic         rx_overflow,
  input wire logic         rx_missing_sop,
  input wire logic         ctl_word_valid,
  input wire logic         ctl_word_last,
  input wire logic         control_crc_fault,
  input wire logic         rx_burst_fault
);
  // Lanes that have shown a sync word since reset.
  logic [11:0] seen_r;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      seen_r <= 12'h000;
    end else begin
      seen_r <= seen_r | lane_mf_sync;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  tx_delay_a: assert property (
    $past(nrst) |-> serdes_tx_data == $past(user_tx_data))
    else $error("transmit data not one cycle late");
  overflow_cause_a: assert property (
    rx_overflow |-> $past(rx_beat_valid && user_valid && !user_ready))
    else $error("overflow without a stalled beat");
  msop_cause_a: assert property (
    rx_missing_sop |-> $past(rx_beat_valid && !rx_beat_sop))
    else $error("missing start flag without cause");
  misalign_cause_a: assert property (
    rx_misaligned |-> $past(|lane_mf_sync && !(&lane_mf_sync)))
    else $error("misaligned without split sync");
  misalign_hunt_a: assert property (
    !(&seen_r) |-> !rx_misaligned)
    else $error("misaligned before all lanes synced");
  aligned_rise_a: assert property (
    $rose(rx_aligned) |-> $past(&lane_mf_sync))
    else $error("aligned without common sync");
  crc_cause_a: assert property (
    control_crc_fault |-> $past(ctl_word_valid && ctl_word_last))
    else $error("crc fault outside span end");
  burst_cause_a: assert property (
    rx_burst_fault |-> $past(rx_beat_valid && (rx_burst_end || rx_beat_eop)))
    else $error("burst fault outside burst end");
endmodule
bind rla_rx_status rla_rx_status_checker i_rla_rx_status_checker (.*);

/* File: tb/rla_lane_tx_model.sv */
/*
 * Remote transmitter model: sync words on all lanes every MF_WORDS
 * words, lane 0 optionally one cycle late, frames optionally bad.
 * Assumes the receiver's clock and reset.
 */
`timescale 1ns/1ns
module rla_lane_tx_model #(
  parameter int MF_WORDS = 16
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        skew,
  input  wire logic        bad,
  output logic      [11:0] lane_word_valid,
  output logic      [11:0] lane_mf_sync,
  output logic      [11:0] lane_mf_bad
);
  logic [15:0] cnt_r;
  logic        late_r;
  logic        sync_all;
  assign sync_all = nrst && (cnt_r == 16'h0000);
  always_ff @(posedge clk) begin
    if (!nrst || cnt_r == 16'(MF_WORDS - 1)) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
    late_r <= sync_all;
  end
  assign lane_word_valid = {12{nrst}};
  assign lane_mf_sync = {{11{sync_all}}, skew ? late_r : sync_all};
  assign lane_mf_bad = {12{bad && sync_all}};
endmodule

/* File: tb/rla_rx_status_tb_top.sv */
/*
 * Self-checking testbench for rla_rx_status.
 * Assumes a 25 MHz clock and the default lane mask.
 */
`timescale 1ns/1ns
module rla_rx_status_tb_top;
  import rla_pkg::*;
  logic         clk, nrst, reg_we, reg_re, irq, skew, bad, user_ready;
  logic         ctl_word_valid, ctl_word_first, ctl_word_last;
  logic         rx_beat_valid, rx_beat_sop, rx_beat_eop, rx_burst_end;
  logic         user_valid, user_sop, user_eop, rx_aligned;
  logic         transceiver_soft_reset, transceiver_loopback_ctl;
  logic         rx_misaligned, rx_align_fault, control_crc_fault;
  logic         rx_missing_sop, rx_missing_eop, rx_overflow;
  logic         rx_burst_fault, rx_burstmax_fault;
  logic [7:0]   reg_addr;
  logic [31:0]  reg_wdata, reg_rdata, rv;
  logic [11:0]  lane_word_valid, lane_mf_sync, lane_mf_bad;
  logic [11:0]  lane_frame_length_fault, lane_frame_repeat_fault;
  logic [63:0]  ctl_word_data;
  logic [23:0]  ctl_crc_rx;
  logic [6:0]   rx_beat_bytes;
  logic [767:0] serdes_rx_data, user_data, user_tx_data, serdes_tx_data;
  logic [767:0] cap_data;
  logic [1:0]   cap_se;
  logic [8:0]   ev, seen;
  int           n_mismatch, comparisons;
  localparam logic [767:0] PA = {24{32'ha5a50001}};
  rla_rx_status i_rla_rx_status (.*);
  rla_lane_tx_model i_rla_lane_tx_model (.*);
  assign ev = {lane_frame_length_fault[0], rx_misaligned, rx_align_fault,
               control_crc_fault, rx_missing_sop, rx_missing_eop,
               rx_overflow, rx_burst_fault, rx_burstmax_fault};
  always @(posedge clk) begin
    seen <= seen | ev;
    if (user_valid && user_ready) begin
      cap_data <= user_data;
      cap_se <= {user_sop, user_eop};
    end
  end
  // ---------------------------------------------------------------
  // Bus cycles and comparison.
  // ---------------------------------------------------------------
  task chk(input logic [767:0] got, input logic [767:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask
  task beat(input logic [2:0] f, input logic [6:0] n, input logic [767:0] d);
    @(posedge clk);
    rx_beat_valid <= 1'b1;
    {rx_beat_sop, rx_beat_eop, rx_burst_end} <= f;
    rx_beat_bytes <= n;
    serdes_rx_data <= d;
    @(posedge clk);
    rx_beat_valid <= 1'b0;
  endtask
  function automatic logic [23:0] crc24(input logic [63:0] d);
    logic [23:0] c;
    c = CRC24_INIT;
    for (int i = 63; i >= 0; i--) begin
      c = {c[22:0], 1'b0} ^ ((c[23] ^ d[i]) ? CRC24_POLY : 24'h000000);
    end
    return c;
  endfunction
  // ---------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------
  task t_regs;
    rd(OFS_MF_LEN);
    chk(rv, 32'h00000800);
    rd(OFS_BURST);
    chk(rv, 32'h00002003);
    rd(8'h40);
    chk(rv, 32'h00000000);
    wr(OFS_CTRL, 32'h00000003);
    cyc(1);
    chk({transceiver_soft_reset, transceiver_loopback_ctl}, 2'h3);
    wr(OFS_CTRL, 32'h00000000);
    cyc(1);
    chk({transceiver_soft_reset, transceiver_loopback_ctl}, 2'h0);
  endtask
  task t_align;
    wr(OFS_MF_LEN, 32'h00000010);
    for (int i = 0; i < 200 && rx_aligned !== 1'b1; i++) cyc(1);
    chk(rx_aligned, 1'b1);
    cyc(40);
    seen = '0;
    cyc(40);
    chk(seen, 9'h000);
  endtask
  task t_skew;
    wr(OFS_INT_STAT, 32'h000003ff);
    wr(OFS_INT_MASK, 32'h00000001);
    seen = '0;
    @(posedge clk) skew <= 1'b1;
    cyc(40);
    chk(rx_aligned, 1'b0);
    chk(seen & 9'h1c0, 9'h1c0);
    @(posedge clk) skew <= 1'b0;
    cyc(40);
    chk(rx_aligned, 1'b1);
    chk(irq, 1'b1);
    rd(OFS_INT_STAT);
    chk(rv & 32'h3, 32'h3);
    wr(OFS_INT_STAT, 32'h00000001);
    cyc(1);
    chk(irq, 1'b0);
    wr(OFS_INT_STAT, 32'h000003ff);
  endtask
  task t_repeat;
    @(posedge clk) bad <= 1'b1;
    cyc(100);
    chk(lane_frame_repeat_fault, 12'hfff);
    @(posedge clk) bad <= 1'b0;
    cyc(40);
    chk(lane_frame_repeat_fault, 12'h000);
  endtask
  task t_crc;
    for (int k = 0; k < 2; k++) begin
      seen = '0;
      @(posedge clk);
      {ctl_word_valid, ctl_word_first, ctl_word_last} <= 3'h7;
      ctl_word_data <= 64'h0123456789abcdef;
      ctl_crc_rx <= crc24(64'h0123456789abcdef) ^ 24'(k);
      @(posedge clk);
      {ctl_word_valid, ctl_word_first, ctl_word_last} <= 3'h0;
      cyc(3);
      chk(seen, 9'(k) << 5);
    end
  endtask
  task t_stream;
    seen = '0;
    beat(3'h0, 7'h40, PA);
    beat(3'h6, 7'h40, ~PA);
    cyc(3);
    chk(seen, 9'h018);
    chk(cap_se, 2'h3);
    chk(cap_data, PA);
  endtask
  task t_burst;
    wr(OFS_BURST, 32'h00002000);
    seen = '0;
    beat(3'h5, 7'h08, PA);
    beat(3'h0, 7'h40, PA);
    beat(3'h3, 7'h40, PA);
    cyc(3);
    chk(seen, 9'h003);
    wr(OFS_BURST, 32'h00002001);
    seen = '0;
    beat(3'h4, 7'h40, PA);
    beat(3'h3, 7'h40, PA);
    cyc(3);
    chk(seen, 9'h000);
    @(posedge clk) user_ready <= 1'b0;
    seen = '0;
    repeat (3) beat(3'h6, 7'h40, PA);
    cyc(2);
    chk(seen, 9'h004);
    @(posedge clk) user_ready <= 1'b1;
    wr(OFS_BURST, 32'h00002003);
  endtask
  task t_tx;
    @(posedge clk) user_tx_data <= {24{32'hc3c35a5a}};
    cyc(1);
    chk(serdes_tx_data, {24{32'hc3c35a5a}});
  endtask
  task finish_test;
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    finish_test;
  end
  initial begin
    {nrst, reg_we, reg_re, skew, bad, ctl_word_valid, ctl_word_first} = '0;
    {ctl_word_last, rx_beat_valid, rx_beat_sop, rx_beat_eop} = '0;
    {rx_burst_end, rx_beat_bytes, reg_addr, reg_wdata, seen} = '0;
    {ctl_word_data, ctl_crc_rx, serdes_rx_data, user_tx_data} = '0;
    user_ready = 1'b1;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_regs;
    t_align;
    t_skew;
    t_repeat;
    t_crc;
    t_stream;
    t_burst;
    t_tx;
    finish_test;
  end
endmodule
